/* hdl/gp_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gp_timer_cfg.svh"
module gp_timer
  import gp_timer_pkg::*;
#(
  parameter int RTC_DIV = `RTC_DIV
)
(
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [31:0] rdata_o,
  input  wire logic        ccp_i,
  output logic             pwm_o
);

  // Divider is 16 bits wide; a ratio below 2 leaves no room to count
  if (RTC_DIV < 2 || RTC_DIV > 65536)
  begin : g_bad_div
    $error("RTC_DIV out of range");
  end

  // ****************************************
  // Functions
  // ****************************************
  function automatic mode_type decode_mode(input logic [2:0] cfg, input logic [3:0] md);
    mode_type m;
    m = M_IDLE;
    if (cfg == `CFG_ONE_PER)
      m = (md[1:0] == `MODE_ONE) ? M_ONE32 : (md[1:0] == `MODE_PER) ? M_PER32 : M_IDLE;
    else if (cfg == `CFG_RTC)
      m = M_RTC;
    else if (cfg[2])
    begin
      unique case (md[1:0])
        `MODE_ONE: m = M_ONE16;
        `MODE_PER: m = M_PER16;
        `MODE_CAP: m = md[`MODE_CMR] ? M_ETIME : M_ECNT;
        default:   m = M_IDLE;
      endcase
    end
    return m;
  endfunction

  function automatic logic edge_hit(input logic rise, input logic fall, input logic [1:0] ev);
    logic h;
    h = rise;
    unique case (ev)
      `EV_FALL: h = fall;
      `EV_BOTH: h = rise | fall;
      default:  h = rise;
    endcase
    return h;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic       [2:0]  cfg_r;
  logic       [3:0]  mode_r;
  logic              en_r;
  logic              stall_r;
  logic       [1:0]  ev_r;
  logic              rtc_stall_override_bit_r;
  logic              inv_r;
  status_type        mask_r;
  status_type        raw_r;
  logic       [31:0] load_r;
  logic       [31:0] match_r;
  logic       [7:0]  presc_r;
  logic       [31:0] cnt_r;
  logic       [31:0] cap_r;
  logic       [7:0]  pre_cnt_r;
  logic       [15:0] rtc_div_r;
  logic              pwm_lvl_r;
  logic       [2:0]  pin_r;

  // ****************************************
  // Decode
  // ****************************************
  mode_type          mode;
  logic              is16;
  logic              pwm_mode;
  logic       [31:0] width_mask;
  logic       [31:0] cnt_m;
  logic       [31:0] load_eff;
  logic       [31:0] match_m;
  logic       [31:0] cnt_dec;
  logic              cnt_zero;
  logic              run;
  logic              tick;
  logic              sec_tick;
  logic              edge_q;
  logic              ec_hit;
  logic              to_hit;
  logic              rtc_hit;
  logic              ce_hit;
  logic              wr_ctl;
  logic              wr_load;
  logic              wr_cfg;
  logic              wr_clear;
  status_type        set_st;

  assign mode       = decode_mode(cfg_r, mode_r);
  assign is16       = cfg_r[2];
  // PWM is periodic 16-bit plus alternate mode; no status logic hangs off it
  assign pwm_mode   = (mode == M_PER16) && mode_r[`MODE_AMS] && !mode_r[`MODE_CMR];
  assign width_mask = is16 ? 32'h0000ffff : 32'hffffffff;
  assign cnt_m      = cnt_r & width_mask;
  assign load_eff   = load_r & width_mask;
  assign match_m    = match_r & width_mask;
  assign cnt_dec    = (cnt_m - 32'h00000001) & width_mask;
  assign cnt_zero   = (cnt_m == 32'h00000000);
  // Clock mode ignores stall when its override is set
  assign run        = en_r && !(stall_r && !(mode == M_RTC && rtc_stall_override_bit_r));
  // Prescaler only in 16-bit one-shot, periodic and PWM
  assign tick       = (mode == M_ONE16 || mode == M_PER16) ? (pre_cnt_r == 8'h00) : 1'b1;
  assign edge_q     = edge_hit(pin_r[1] & ~pin_r[2], ~pin_r[1] & pin_r[2], ev_r);
  assign sec_tick   = pin_r[1] & ~pin_r[2] && (rtc_div_r == 16'(RTC_DIV - 1));
  assign ec_hit     = run && mode == M_ECNT && edge_q && (cnt_dec == match_m);
  assign ce_hit     = run && mode == M_ETIME && edge_q;
  assign to_hit     = run && tick && cnt_zero && !pwm_mode &&
                      (mode == M_ONE32 || mode == M_PER32 || mode == M_ONE16 || mode == M_PER16);
  assign rtc_hit    = run && mode == M_RTC && sec_tick && (cnt_r == match_r);
  assign wr_ctl     = we_i && addr_i == `OFS_CTL;
  assign wr_load    = we_i && addr_i == `OFS_LOAD;
  assign wr_cfg     = we_i && addr_i == `OFS_CFG;
  assign wr_clear   = we_i && addr_i == `OFS_CLEAR;

  always_comb
  begin
    set_st          = 4'h0;
    set_st[`ST_TO]  = to_hit;
    set_st[`ST_CM]  = ec_hit;
    set_st[`ST_CE]  = ce_hit;
    set_st[`ST_RTC] = rtc_hit;
  end

  // ****************************************
  // Pin synchroniser
  // ****************************************
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pin_r <= 3'h0;
    else
      pin_r <= {pin_r[1:0], ccp_i};
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg_r   <= 3'h0;
      mode_r  <= 4'h0;
      stall_r <= 1'b0;
      ev_r    <= 2'h0;
      rtc_stall_override_bit_r <= 1'b0;
      inv_r   <= 1'b0;
      mask_r  <= 4'h0;
      load_r  <= `LOAD_RST;
      match_r <= `LOAD_RST;
      presc_r <= 8'h00;
    end
    else if (we_i)
    begin
      unique case (addr_i)
        `OFS_CFG:   cfg_r   <= wdata_i[2:0];
        `OFS_MODE:  mode_r  <= wdata_i[3:0];
        `OFS_CTL:
        begin
          stall_r <= wdata_i[`CTL_STALL];
          ev_r    <= wdata_i[`CTL_EV_HI:`CTL_EV_LO];
          rtc_stall_override_bit_r <= wdata_i[`CTL_RTC_STALL_OVERRIDE_BIT];
          inv_r   <= wdata_i[`CTL_INV];
        end
        `OFS_MASK:  mask_r  <= wdata_i[3:0];
        `OFS_LOAD:  load_r  <= wdata_i;
        `OFS_MATCH: match_r <= wdata_i;
        `OFS_PRESC: presc_r <= wdata_i[7:0];
        default:    ;
      endcase
    end
  end

  // ****************************************
  // Enable
  // ****************************************
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      en_r <= 1'b0;
    else if (wr_ctl)
      en_r <= wdata_i[`CTL_EN];
    else if (ec_hit)
      en_r <= 1'b0;
    else if (to_hit && (mode == M_ONE32 || mode == M_ONE16))
      en_r <= 1'b0;
  end

  // ****************************************
  // Prescaler and clock-mode divider
  // ****************************************
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pre_cnt_r <= 8'h00;
    else if (!run || pre_cnt_r == 8'h00)
      pre_cnt_r <= presc_r;
    else
      pre_cnt_r <= pre_cnt_r - 8'h01;
  end

  // Divider counts rising pin edges, so the pin rate sets the one-second tick
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rtc_div_r <= 16'h0000;
    else if (mode != M_RTC || !en_r)
      rtc_div_r <= 16'h0000;
    else if (sec_tick)
      rtc_div_r <= 16'h0000;
    else if (pin_r[1] & ~pin_r[2])
      rtc_div_r <= rtc_div_r + 16'h0001;
  end

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_r <= `LOAD_RST;
    else if (wr_cfg && wdata_i[2:0] == `CFG_RTC)
      cnt_r <= `RTC_FIRST;
    else if (wr_load && mode != M_RTC)
      cnt_r <= wdata_i & width_mask;
    else if (run)
    begin
      unique case (mode)
        M_ONE32, M_PER32, M_ONE16, M_PER16:
          if (tick)
            cnt_r <= cnt_zero ? load_eff : cnt_dec;
        M_ETIME:
          cnt_r <= cnt_zero ? load_eff : cnt_dec;
        M_ECNT:
          if (edge_q)
            cnt_r <= ec_hit ? load_eff : cnt_dec;
        M_RTC:
          if (sec_tick)
            cnt_r <= (cnt_r == match_r) ? 32'h00000000 : cnt_r + 32'h00000001;
        M_IDLE:
          cnt_r <= cnt_r;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cap_r <= `LOAD_RST;
    else if (ce_hit)
      cap_r <= cnt_m;
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Set wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      raw_r <= 4'h0;
    else if (wr_clear)
      raw_r <= (raw_r & ~wdata_i[3:0]) | set_st;
    else
      raw_r <= raw_r | set_st;
  end

  // ****************************************
  // PWM output
  // ****************************************
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pwm_lvl_r <= 1'b0;
    else if (!pwm_mode)
      pwm_lvl_r <= 1'b0;
    else if (run && tick && cnt_m == load_eff)
      pwm_lvl_r <= 1'b1;
    else if (run && tick && cnt_m == match_m)
      pwm_lvl_r <= 1'b0;
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pwm_o <= 1'b0;
    else
      pwm_o <= pwm_lvl_r ^ inv_r;
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 32'h00000000;
    else if (!re_i)
      rdata_o <= 32'h00000000;
    else
    begin
      unique case (addr_i)
        `OFS_CFG:    rdata_o <= {29'h0, cfg_r};
        `OFS_MODE:   rdata_o <= {28'h0, mode_r};
        `OFS_CTL:    rdata_o <= {25'h0, inv_r, 1'b0, rtc_stall_override_bit_r, ev_r, stall_r, en_r};
        `OFS_MASK:   rdata_o <= {28'h0, mask_r};
        `OFS_RAW:    rdata_o <= {28'h0, raw_r};
        `OFS_MSK_ST: rdata_o <= {28'h0, raw_r & mask_r};
        `OFS_LOAD:   rdata_o <= load_r;
        `OFS_MATCH:  rdata_o <= match_r;
        `OFS_PRESC:  rdata_o <= {24'h0, presc_r};
        `OFS_VALUE:  rdata_o <= (mode == M_ETIME) ? cap_r : cnt_m;
        default:     rdata_o <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_EC_STOP: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ec_hit && !we_i |=> !en_r && raw_r[`ST_CM] && cnt_m == $past(load_eff))
    else $error("edge count match did not stop and reload");

  AST_EC_DEC: assert property (@(posedge clock_i) disable iff (!rstn_i)
    run && mode == M_ECNT && edge_q && !ec_hit && !we_i |=> cnt_m == $past(cnt_dec))
    else $error("edge count did not decrement by one");

  AST_EC_IGNORE: assert property (@(posedge clock_i) disable iff (!rstn_i)
    mode == M_ECNT && !en_r && !we_i |=> $stable(cnt_r))
    else $error("disabled edge count moved");

  AST_ET_CAP: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_hit |=> cap_r == $past(cnt_m) && raw_r[`ST_CE])
    else $error("edge time capture wrong");

  AST_ET_RELOAD: assert property (@(posedge clock_i) disable iff (!rstn_i)
    run && mode == M_ETIME && cnt_zero && !we_i |=> cnt_m == $past(load_eff) && en_r)
    else $error("edge time reload wrong");

  AST_PWM_NOFLAG: assert property (@(posedge clock_i) disable iff (!rstn_i)
    pwm_mode |=> (raw_r & ~$past(raw_r)) == 4'h0)
    else $error("flag set in PWM mode");

  AST_PWM_HIGH: assert property (@(posedge clock_i) disable iff (!rstn_i)
    pwm_mode && run && tick && cnt_m == load_eff && !we_i |-> ##2 (pwm_o != $past(inv_r, 2)))
    else $error("PWM output not asserted at load value");

  AST_PWM_LOW: assert property (@(posedge clock_i) disable iff (!rstn_i)
    pwm_mode && run && tick && cnt_m == match_m && cnt_m != load_eff |=> !pwm_lvl_r)
    else $error("PWM level not cleared at match");

  AST_FLAG_HOLD: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !wr_clear |=> (raw_r & $past(raw_r)) == $past(raw_r))
    else $error("flag lost without clear");

  AST_ONESHOT: assert property (@(posedge clock_i) disable iff (!rstn_i)
    to_hit && mode == M_ONE16 && !we_i |=> !en_r ##1 $stable(cnt_r))
    else $error("one-shot did not stop");

  AST_RTC_WRAP: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rtc_hit && !we_i |=> cnt_r == 32'h00000000 && en_r && raw_r[`ST_RTC])
    else $error("clock mode did not restart from zero");

endmodule
`default_nettype wire

/* hdl/gp_timer_cfg.svh */
`ifndef GP_TIMER_CFG_SVH
`define GP_TIMER_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CFG     12'h000
`define OFS_MODE    12'h004
`define OFS_CTL     12'h00c
`define OFS_MASK    12'h018
`define OFS_RAW     12'h01c
`define OFS_MSK_ST  12'h020
`define OFS_CLEAR   12'h024
`define OFS_LOAD    12'h028
`define OFS_MATCH   12'h030
`define OFS_PRESC   12'h038
`define OFS_VALUE   12'h048

// ****************************************
// Field positions and codes
// ****************************************
`define CFG_RTC     3'h1
`define CFG_ONE_PER 3'h0
`define MODE_ONE    2'h1
`define MODE_PER    2'h2
`define MODE_CAP    2'h3
`define MODE_CMR    2
`define MODE_AMS    3
`define CTL_EN      0
`define CTL_STALL   1
`define CTL_EV_LO   2
`define CTL_EV_HI   3
`define CTL_RTC_STALL_OVERRIDE_BIT   4
`define CTL_INV     6
`define EV_RISE     2'h0
`define EV_FALL     2'h1
`define EV_BOTH     2'h3
`define ST_TO       0
`define ST_CM       1
`define ST_CE       2
`define ST_RTC      3

// ****************************************
// Reset values and timing
// ****************************************
`define LOAD_RST    32'hffffffff
`define RTC_FIRST   32'h00000001
`define RTC_DIV     32768

`endif

/* hdl/gp_timer_pkg.sv */
`default_nettype none
package gp_timer_pkg;
  typedef enum logic [2:0] {
    M_IDLE  = 3'h0,
    M_ONE32 = 3'h1,
    M_PER32 = 3'h3,
    M_RTC   = 3'h2,
    M_ONE16 = 3'h6,
    M_PER16 = 3'h7,
    M_ECNT  = 3'h5,
    M_ETIME = 3'h4
  } mode_type;
  typedef logic [3:0] status_type;
endpackage
`default_nettype wire

/* testbench/ccp_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ccp_model
(
  input  wire logic clock_i,
  output logic      ccp_o
);
  // ****
  // Pin drive
  // ****
  initial ccp_o = 1'b0;

  // Each level held two clocks or more, else the synchroniser may merge edges
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n)
    begin
      @(posedge clock_i);
      ccp_o <= 1'b1;
      repeat (hi) @(posedge clock_i);
      ccp_o <= 1'b0;
      repeat (lo - 1) @(posedge clock_i);
    end
  endtask
endmodule
`default_nettype wire

/* testbench/gp_timer_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gp_timer_cfg.svh"
module gp_timer_test;
  import gp_timer_pkg::*;
  // ****
  // Bench
  // ****
  logic        clock_i;
  logic        rstn_i;
  logic [11:0] addr_i;
  logic [31:0] wdata_i;
  logic        we_i;
  logic        re_i;
  wire  [31:0] rdata_o;
  wire         ccp_i;
  wire         pwm_o;
  logic        re_d = 1'b0;
  logic [31:0] exp_q[$];
  logic [15:0] ld;
  logic [1:0]  ev;
  logic [1:0]  evs[3] = '{`EV_RISE, `EV_FALL, `EV_BOTH};
  int          failures = 0;
  int          total_checks = 0;
  int          seed = 32'h24585183;
  int          n;

  // Short clock-mode divider keeps the run brief
  gp_timer #(.RTC_DIV(4)) gp_timer_i
  (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .addr_i  (addr_i),
    .wdata_i (wdata_i),
    .we_i    (we_i),
    .re_i    (re_i),
    .rdata_o (rdata_o),
    .ccp_i   (ccp_i),
    .pwm_o   (pwm_o)
  );
  ccp_model ccp_model_i
  (
    .clock_i (clock_i),
    .ccp_o   (ccp_i)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // ****
  // Tasks
  // ****
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clock_i);
    we_i <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr_i <= a;
    re_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock_i);
    re_i <= 1'b0;
  endtask

  task automatic wrap_up();
    if (failures == 0 && total_checks > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clock_i)
  begin
    re_d <= re_i;
    if (re_d === 1'b1)
    begin
      cmp(rdata_o, exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (60000) @(posedge clock_i);
    failures++;
    wrap_up();
  end

  // ****
  // Sequence
  // ****
  initial
  begin
    rstn_i = 1'b0;
    addr_i = 12'h000;
    wdata_i = 32'h0;
    we_i = 1'b0;
    re_i = 1'b0;
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(`OFS_CFG, 32'h0);
    rd(`OFS_MODE, 32'h0);
    rd(`OFS_CTL, 32'h0);
    rd(`OFS_RAW, 32'h0);
    rd(`OFS_LOAD, 32'hffffffff);
    rd(`OFS_MATCH, 32'hffffffff);
    rd(`OFS_PRESC, 32'h0);
    wr(12'h100, 32'h5);
    rd(12'h100, 32'h0);
    rd(`OFS_CLEAR, 32'h0);
    // Edge count, every event code
    wr(`OFS_CFG, 32'h4);
    wr(`OFS_MODE, 32'h3);
    wr(`OFS_MASK, 32'h2);
    for (int i = 0; i < 3; i++)
    begin
      ev = evs[i];
      ld = 16'h0010 + 16'($unsigned($random(seed)) % 1000);
      wr(`OFS_CTL, {28'h0, ev, 2'h0});
      wr(`OFS_LOAD, {16'h0, ld});
      wr(`OFS_MATCH, {16'h0, ld - 16'h4});
      wr(`OFS_CTL, {28'h0, ev, 2'h1});
      ccp_model_i.pulses(2, 3, 4);
      rd(`OFS_RAW, (ev == `EV_BOTH) ? 32'h2 : 32'h0);
      rd(`OFS_VALUE, {16'h0, (ev == `EV_BOTH) ? ld : ld - 16'h2});
      ccp_model_i.pulses(2, 3, 4);
      rd(`OFS_VALUE, {16'h0, ld});
      rd(`OFS_CTL, {28'h0, ev, 2'h0});
      rd(`OFS_MSK_ST, 32'h2);
      wr(`OFS_CLEAR, 32'h4);
      rd(`OFS_RAW, 32'h2);
      wr(`OFS_CLEAR, 32'h2);
      rd(`OFS_RAW, 32'h0);
    end
    // Edge time
    wr(`OFS_CTL, 32'h0);
    wr(`OFS_MODE, 32'h7);
    wr(`OFS_LOAD, 32'h20);
    wr(`OFS_MASK, 32'h4);
    wr(`OFS_CTL, 32'h1);
    repeat (100) @(posedge clock_i);
    ccp_model_i.pulses(1, 4, 4);
    rd(`OFS_RAW, 32'h4);
    rd(`OFS_MSK_ST, 32'h4);
    // Edge seen 103 clocks after enable; period is load plus one
    rd(`OFS_VALUE, 32'h1c);
    // PWM, plain then inverted
    wr(`OFS_CTL, 32'h0);
    wr(`OFS_CLEAR, 32'hf);
    wr(`OFS_MODE, 32'ha);
    wr(`OFS_LOAD, 32'h9);
    wr(`OFS_MATCH, 32'h3);
    for (int inv = 0; inv < 2; inv++)
    begin
      wr(`OFS_CTL, inv ? 32'h41 : 32'h1);
      repeat (20) @(posedge clock_i);
      n = 0;
      repeat (40)
      begin
        @(posedge clock_i);
        if (pwm_o === 1'b1)
        begin
          n++;
        end
      end
      cmp(32'(n), inv ? 32'h10 : 32'h18);
      wr(`OFS_CTL, 32'h0);
    end
    rd(`OFS_RAW, 32'h0);
    // One-shot and periodic, 32 and 16 bit
    for (int c = 0; c < 2; c++)
    begin
      for (int m = 1; m < 3; m++)
      begin
        wr(`OFS_CTL, 32'h0);
        wr(`OFS_CLEAR, 32'hf);
        wr(`OFS_CFG, c ? 32'h4 : 32'h0);
        wr(`OFS_MODE, 32'(m));
        wr(`OFS_PRESC, 32'h1);
        wr(`OFS_LOAD, 32'h4);
        wr(`OFS_CTL, 32'h1);
        repeat (30) @(posedge clock_i);
        rd(`OFS_RAW, 32'h1);
        rd(`OFS_CTL, (m == 1) ? 32'h0 : 32'h1);
        wr(`OFS_CTL, 32'h0);
        wr(`OFS_CLEAR, 32'h2);
        rd(`OFS_RAW, 32'h1);
        wr(`OFS_CLEAR, 32'h1);
        rd(`OFS_RAW, 32'h0);
      end
    end
    // Clock mode, stalled but overridden
    wr(`OFS_CTL, 32'h0);
    wr(`OFS_CFG, 32'h1);
    wr(`OFS_MATCH, 32'h2);
    wr(`OFS_MASK, 32'h8);
    wr(`OFS_CTL, 32'h13);
    ccp_model_i.pulses(12, 2, 2);
    rd(`OFS_MSK_ST, 32'h8);
    wr(`OFS_CLEAR, 32'h8);
    ccp_model_i.pulses(12, 2, 2);
    rd(`OFS_RAW, 32'h8);
    repeat (4) @(posedge clock_i);
    wrap_up();
  end
endmodule
`default_nettype wire
